// *** verilog/afec_pkg.sv ***
// Constants and carrier types for the antenna fault escalation block
// What this block does
// RULE1: Each fault trigger fires exactly one fixed 100 ms cut-off pulse.
// RULE2: The fault trigger also sets a trip indicator latch that outlives the pulse.
// RULE3: Disable forces the outgoing cut-off pulse off; detection and trip keep working.
// RULE4: RF drive is inhibited for the whole time a cut-off pulse is active.
// RULE5: Four cut-off pulses inside one 90 s window command low power.
// RULE6: The pulse counter clears by itself at the end of every window.
// RULE7: Four more pulses after low power assert plate_supply_shutdown_latch, held until manual reset.
// RULE8: After manual reclose the transmitter stays low until high power is commanded.
// RULE9: Window length selects 15, 30, 60 or 90 s, 90 s by default.
// RULE10: Defeat option lights low power indicator but keeps full power; plate_supply_shutdown_latch still follows.
// RULE11: Window starts at first pulse after a clear; window-end clear is momentary.
// RULE12: Low power command is a 20 ms momentary closure, not a level.
// RULE13: First pulse latches protection indicator; after plate_supply_shutdown_latch it flashes at 2 Hz.
// RULE14: Fault and manual reset inputs are synchronised and edge detected.
package afec_pkg;
  localparam int          CLK_HZ       = 20_000_000;
  localparam int          MS_CYC       = CLK_HZ / 1000;
  localparam int          PULSE_MS     = 100;
  localparam int          PULSE_CYC    = PULSE_MS * MS_CYC;
  localparam int          LOWP_MS      = 20;
  localparam int          LOWP_CYC     = LOWP_MS * MS_CYC;
  localparam int          FLASH_HZ     = 2;
  localparam int          FLASH_CYC    = CLK_HZ / (2 * FLASH_HZ);
  localparam int          SEC_CYC      = CLK_HZ;
  localparam logic [2:0]  TRIP_COUNT   = 3'h4;
  localparam logic [6:0]  WIN_15_S     = 7'h0F;
  localparam logic [6:0]  WIN_30_S     = 7'h1E;
  localparam logic [6:0]  WIN_60_S     = 7'h3C;
  localparam logic [6:0]  WIN_90_S     = 7'h5A;
  localparam logic [1:0]  WSEL_90      = 2'h0;
  localparam logic [1:0]  WSEL_15      = 2'h1;
  localparam logic [1:0]  WSEL_30      = 2'h2;
  localparam logic [1:0]  WSEL_60      = 2'h3;
  localparam int          IN_FAULT     = 0;
  localparam int          IN_MRST      = 1;
  localparam int          IN_HIPWR     = 2;
  localparam int          IN_W         = 3;

  typedef enum logic [1:0] {
    AFEC_ST_NORMAL,
    AFEC_ST_LOWP,
    AFEC_ST_LOCK
  } afec_stage_t;

  typedef struct packed {
    logic       op_disable;
    logic       defeat_lowp;
    logic [1:0] win_sel;
  } afec_cfg_t;

  typedef struct packed {
    logic fault_trip_indicator;
    logic low_power_indicator;
    logic plate_supply_shutdown_latch;
    logic protection_operated_indicator;
  } afec_ind_t;
endpackage

// *** verilog/afec_sync_edge.sv ***
// Two-stage synchroniser with rising edge detect per input bit
module afec_sync_edge #(
  parameter int W = 3
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] rise_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // Per bit: meta feeds only sync, edge taken from sync and prev
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    logic meta_next;
    logic sync_next;
    logic prev_next;
    always_comb begin
      meta_next = d_in[g];
      sync_next = meta_reg[g];
      prev_next = sync_reg[g];
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        meta_reg[g] <= 1'b0;
        sync_reg[g] <= 1'b0;
        prev_reg[g] <= 1'b0;
      end else begin
        meta_reg[g] <= meta_next;
        sync_reg[g] <= sync_next;
        prev_reg[g] <= prev_next;
      end
    end
    // RULE14 single edge
    assign rise_out[g] = sync_reg[g] & ~prev_reg[g];

    property p_one_edge;
      @(posedge clk_in) disable iff (!rst_b_in)
      rise_out[g] |=> !rise_out[g] ##1 !rise_out[g];
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("edge lasted too long"); // RULE14
  end
endmodule

// *** verilog/afec_oneshot.sv ***
// Non-retriggerable one-shot producing a fixed number of busy cycles
module afec_oneshot #(
  parameter int unsigned N = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic start_in,
  output logic      busy_out
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        busy_reg;
  logic        busy_next;

  ////////////////////////////////////////////////////////////////////////
  // RULE1 fixed length
  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_reg;
    if (!busy_reg) begin
      busy_next = start_in;       // Triggers while busy are ignored
      cnt_next  = 32'h0;
    end else if (cnt_reg == 32'(N - 1)) begin
      busy_next = 1'b0;
      cnt_next  = 32'h0;
    end else begin
      cnt_next  = cnt_reg + 32'h1;
    end
  end

  // Register stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= 32'h0;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign busy_out = busy_reg;

  property p_shot_len;
    @(posedge clk_in) disable iff (!rst_b_in)
    $fell(busy_reg) |-> $past(cnt_reg) == 32'(N - 1);
  endproperty
  a_shot_len: assert property (p_shot_len) else $error("one-shot length wrong"); // RULE1
endmodule

// *** verilog/afec_top.sv ***
// Antenna fault escalation control: cut-off pulse, counting, low power, plate_supply_shutdown_latch
module afec_top #(
  parameter int unsigned PULSE_CYC = afec_pkg::PULSE_CYC,
  parameter int unsigned LOWP_CYC  = afec_pkg::LOWP_CYC,
  parameter int unsigned FLASH_CYC = afec_pkg::FLASH_CYC,
  parameter int unsigned SEC_CYC   = afec_pkg::SEC_CYC
) (
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                fault_trig_in,
  input  wire logic                man_reset_in,
  input  wire logic                high_power_cmd_in,
  input  wire afec_pkg::afec_cfg_t cfg_in,
  output logic                     cutoff_pulse_out,
  output logic                     rf_drive_inhibit_out,
  output logic                     low_power_cmd_out,
  output logic                     tx_low_power_out,
  output afec_pkg::afec_ind_t      ind_out
);
  logic [afec_pkg::IN_W-1:0] rise;
  logic                      fault_rise;
  logic                      mrst_rise;
  logic                      hp_rise;
  logic                      shot_busy;
  logic                      lowp_busy;
  logic                      lowp_fire;

  logic                      cut_reg;
  logic                      cut_next;
  logic                      inhib_reg;
  logic                      cnt_ev;
  logic                      lowcmd_reg;

  afec_pkg::afec_stage_t     stage_reg;
  afec_pkg::afec_stage_t     stage_next;
  logic [2:0]                cnt_reg;
  logic [2:0]                cnt_next;
  logic [2:0]                cnt_base;
  logic                      win_on_reg;
  logic                      win_on_next;
  logic                      win_end;
  logic [31:0]               win_cnt_reg;
  logic [31:0]               win_cnt_next;
  logic [31:0]               win_len;
  logic [6:0]                win_s;
  logic                      pwr_low_reg;
  logic                      pwr_low_next;
  logic                      trip_reg;
  logic                      trip_next;
  logic                      prot_reg;
  logic                      prot_next;
  logic                      lowind_reg;
  logic                      lowind_next;
  logic                      flash_reg;
  logic                      flash_next;
  logic [31:0]               flash_cnt_reg;
  logic [31:0]               flash_cnt_next;
  afec_pkg::afec_ind_t       ind_reg;
  afec_pkg::afec_ind_t       ind_next;

  ////////////////////////////////////////////////////////////////////////
  // RULE14 synchronise inputs
  afec_sync_edge #(
    .W (afec_pkg::IN_W)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({high_power_cmd_in, man_reset_in, fault_trig_in}),
    .rise_out (rise)
  );

  assign fault_rise = rise[afec_pkg::IN_FAULT];
  assign mrst_rise  = rise[afec_pkg::IN_MRST];
  assign hp_rise    = rise[afec_pkg::IN_HIPWR];

  // RULE1 cut-off one-shot
  afec_oneshot #(
    .N (PULSE_CYC)
  ) u_cut_shot (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (fault_rise),
    .busy_out (shot_busy)
  );

  // RULE12 momentary low power closure
  afec_oneshot #(
    .N (LOWP_CYC)
  ) u_lowp_shot (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .start_in (lowp_fire),
    .busy_out (lowp_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // RULE3 disable grounds the outgoing pulse, the RF inhibit and the pulse count
  assign cut_next = shot_busy & ~cfg_in.op_disable;
  // Each rising edge of the outgoing pulse is one counted operation
  assign cnt_ev   = cut_next & ~cut_reg;

  // RULE9 window length select
  always_comb begin
    unique case (cfg_in.win_sel)
      afec_pkg::WSEL_15: win_s = afec_pkg::WIN_15_S;
      afec_pkg::WSEL_30: win_s = afec_pkg::WIN_30_S;
      afec_pkg::WSEL_60: win_s = afec_pkg::WIN_60_S;
      afec_pkg::WSEL_90: win_s = afec_pkg::WIN_90_S;
    endcase
  end
  assign win_len = 32'(32'(win_s) * SEC_CYC);
  // RULE6 window end clears
  assign win_end = win_on_reg && (win_cnt_reg >= win_len - 32'h1);

  ////////////////////////////////////////////////////////////////////////
  // Counting window, escalation stage and power level
  always_comb begin
    stage_next   = stage_reg;
    pwr_low_next = pwr_low_reg;
    lowind_next  = lowind_reg;
    lowp_fire    = 1'b0;
    // RULE11 momentary clear at window end
    cnt_base     = win_end ? 3'h0 : cnt_reg;
    win_on_next  = win_on_reg & ~win_end;
    win_cnt_next = win_on_next ? win_cnt_reg + 32'h1 : 32'h0;
    cnt_next     = cnt_base;
    if (cnt_ev && stage_reg != afec_pkg::AFEC_ST_LOCK) begin
      cnt_next = cnt_base + 3'h1;
      // RULE11 window opens on first pulse
      if (!win_on_next) begin
        win_on_next  = 1'b1;
        win_cnt_next = 32'h0;
      end
      if (cnt_next == afec_pkg::TRIP_COUNT) begin
        cnt_next     = 3'h0;
        win_on_next  = 1'b0;
        win_cnt_next = 32'h0;
        unique case (stage_reg)
          afec_pkg::AFEC_ST_NORMAL: begin
            // RULE5 first threshold
            stage_next  = afec_pkg::AFEC_ST_LOWP;
            lowind_next = 1'b1;
            // RULE10 defeat keeps full power
            if (!cfg_in.defeat_lowp) begin
              pwr_low_next = 1'b1;
              lowp_fire    = 1'b1;
            end
          end
          afec_pkg::AFEC_ST_LOWP: begin
            // RULE7 second threshold locks out
            stage_next = afec_pkg::AFEC_ST_LOCK;
          end
          afec_pkg::AFEC_ST_LOCK: begin
            stage_next = afec_pkg::AFEC_ST_LOCK;
          end
        endcase
      end
    end
    // Operator return to full power, refused while locked out
    if (hp_rise && stage_reg != afec_pkg::AFEC_ST_LOCK) begin
      pwr_low_next = 1'b0;
    end
    // RULE8 manual reclose restarts in low power
    if (mrst_rise && stage_reg == afec_pkg::AFEC_ST_LOCK) begin
      stage_next   = afec_pkg::AFEC_ST_NORMAL;
      pwr_low_next = 1'b1;
      lowind_next  = 1'b0;
      cnt_next     = 3'h0;
      win_on_next  = 1'b0;
      win_cnt_next = 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indicators and flasher
  always_comb begin
    // RULE2 trip latch, set wins over clear
    trip_next = fault_rise | (trip_reg & ~mrst_rise);
    // RULE13 protection operated latch
    prot_next = cnt_ev | (prot_reg & ~mrst_rise);
    if (flash_cnt_reg >= FLASH_CYC - 32'h1) begin
      flash_cnt_next = 32'h0;
      flash_next     = ~flash_reg;
    end else begin
      flash_cnt_next = flash_cnt_reg + 32'h1;
      flash_next     = flash_reg;
    end
    ind_next.fault_trip_indicator        = trip_next;
    ind_next.low_power_indicator         = lowind_next;
    // RULE7 plate supply removed while locked
    ind_next.plate_supply_shutdown_latch = (stage_next == afec_pkg::AFEC_ST_LOCK);
    // RULE13 flash after plate_supply_shutdown_latch
    ind_next.protection_operated_indicator =
      (stage_next == afec_pkg::AFEC_ST_LOCK) ? flash_next : prot_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cut_reg       <= 1'b0;
      inhib_reg     <= 1'b0;
      lowcmd_reg    <= 1'b0;
      stage_reg     <= afec_pkg::AFEC_ST_NORMAL;
      cnt_reg       <= 3'h0;
      win_on_reg    <= 1'b0;
      win_cnt_reg   <= 32'h0;
      pwr_low_reg   <= 1'b0;
      lowind_reg    <= 1'b0;
      trip_reg      <= 1'b0;
      prot_reg      <= 1'b0;
      flash_reg     <= 1'b0;
      flash_cnt_reg <= 32'h0;
      ind_reg       <= '0;
    end else begin
      cut_reg       <= cut_next;
      // RULE4 inhibit RF drive with pulse
      inhib_reg     <= cut_next;
      lowcmd_reg    <= lowp_busy;
      stage_reg     <= stage_next;
      cnt_reg       <= cnt_next;
      win_on_reg    <= win_on_next;
      win_cnt_reg   <= win_cnt_next;
      pwr_low_reg   <= pwr_low_next;
      lowind_reg    <= lowind_next;
      trip_reg      <= trip_next;
      prot_reg      <= prot_next;
      flash_reg     <= flash_next;
      flash_cnt_reg <= flash_cnt_next;
      ind_reg       <= ind_next;
    end
  end

  assign cutoff_pulse_out     = cut_reg;
  assign rf_drive_inhibit_out = inhib_reg;
  assign low_power_cmd_out    = lowcmd_reg;
  assign tx_low_power_out     = pwr_low_reg;
  assign ind_out              = ind_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_trip_set;
    @(posedge clk_in) disable iff (!rst_b_in)
    fault_rise |=> ind_out.fault_trip_indicator;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not latched"); // RULE2

  property p_disable_gate;
    @(posedge clk_in) disable iff (!rst_b_in)
    cfg_in.op_disable |=> !cutoff_pulse_out;
  endproperty
  a_disable_gate: assert property (p_disable_gate) else $error("pulse passed disable"); // RULE3

  property p_rf_inhibit;
    @(posedge clk_in) disable iff (!rst_b_in)
    cutoff_pulse_out |-> rf_drive_inhibit_out;
  endproperty
  a_rf_inhibit: assert property (p_rf_inhibit) else $error("RF not inhibited"); // RULE4

  property p_low_step;
    @(posedge clk_in) disable iff (!rst_b_in)
    (stage_reg == afec_pkg::AFEC_ST_NORMAL && cnt_ev && !mrst_rise &&
     cnt_base == afec_pkg::TRIP_COUNT - 3'h1)
    |=> stage_reg == afec_pkg::AFEC_ST_LOWP && ind_out.low_power_indicator;
  endproperty
  a_low_step: assert property (p_low_step) else $error("no low power step"); // RULE5

  property p_win_clear;
    @(posedge clk_in) disable iff (!rst_b_in)
    (win_end && !cnt_ev && !mrst_rise) |=> cnt_reg == 3'h0 && !win_on_reg;
  endproperty
  a_win_clear: assert property (p_win_clear) else $error("window end kept count"); // RULE6

  property p_plate_supply_shutdown_latch;
    @(posedge clk_in) disable iff (!rst_b_in)
    (stage_reg == afec_pkg::AFEC_ST_LOWP && cnt_ev && !mrst_rise &&
     cnt_base == afec_pkg::TRIP_COUNT - 3'h1)
    |=> ind_out.plate_supply_shutdown_latch ##1
        (ind_out.plate_supply_shutdown_latch || $past(mrst_rise));
  endproperty
  a_plate_supply_shutdown_latch: assert property (p_plate_supply_shutdown_latch) else $error("plate_supply_shutdown_latch missing"); // RULE7

  property p_reclose_low;
    @(posedge clk_in) disable iff (!rst_b_in)
    (mrst_rise && stage_reg == afec_pkg::AFEC_ST_LOCK)
    |=> tx_low_power_out && !ind_out.plate_supply_shutdown_latch;
  endproperty
  a_reclose_low: assert property (p_reclose_low) else $error("reclose not low"); // RULE8

  property p_win_len;
    @(posedge clk_in) disable iff (!rst_b_in)
    (win_on_reg && $stable(cfg_in.win_sel)) |-> win_cnt_reg < win_len;
  endproperty
  a_win_len: assert property (p_win_len) else $error("window overran"); // RULE9

  property p_defeat;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cfg_in.defeat_lowp && stage_reg == afec_pkg::AFEC_ST_NORMAL &&
     stage_next == afec_pkg::AFEC_ST_LOWP && !hp_rise)
    |=> tx_low_power_out == $past(tx_low_power_out) && !low_power_cmd_out;
  endproperty
  a_defeat: assert property (p_defeat) else $error("defeat ignored"); // RULE10

  property p_win_open;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cnt_ev && !win_on_reg && cnt_next != 3'h0) |=> win_on_reg;
  endproperty
  a_win_open: assert property (p_win_open) else $error("window not opened"); // RULE11

  property p_lowp_cmd;
    @(posedge clk_in) disable iff (!rst_b_in)
    (lowp_fire && !lowp_busy) |=> ##1 low_power_cmd_out;
  endproperty
  a_lowp_cmd: assert property (p_lowp_cmd) else $error("low power closure missing"); // RULE12

  property p_flash;
    @(posedge clk_in) disable iff (!rst_b_in)
    stage_reg == afec_pkg::AFEC_ST_LOCK |->
      ind_out.protection_operated_indicator == flash_reg;
  endproperty
  a_flash: assert property (p_flash) else $error("indicator not flashing"); // RULE13
endmodule

// *** tb/afec_xmtr_model.sv ***
// Behavioural fault detector, exciter and power controls facing the block
module afec_xmtr_model (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       fault_req_in,
  input  wire logic       cutoff_in,
  input  wire logic       inhibit_in,
  input  wire logic       lowp_cmd_in,
  output logic            fault_trig_out,
  output logic [7:0]      pulse_cnt_out,
  output logic [7:0]      pulse_len_out,
  output logic [7:0]      closure_cnt_out,
  output logic [7:0]      closure_len_out,
  output logic [7:0]      rf_gap_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] run_reg;
  logic [7:0] crun_reg;
  logic       cut_d_reg;
  logic       lpc_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Detector output and observation of the pulse and the power closure
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_trig_out  <= 1'b0;
      pulse_cnt_out   <= 8'h00;
      pulse_len_out   <= 8'h00;
      closure_cnt_out <= 8'h00;
      closure_len_out <= 8'h00;
      rf_gap_out      <= 8'h00;
      run_reg         <= 8'h00;
      crun_reg        <= 8'h00;
      cut_d_reg       <= 1'b0;
      lpc_d_reg       <= 1'b0;
    end else begin
      // Comparator level follows the line condition
      fault_trig_out <= fault_req_in;
      cut_d_reg      <= cutoff_in;
      lpc_d_reg      <= lowp_cmd_in;
      if (cutoff_in && !cut_d_reg) pulse_cnt_out <= pulse_cnt_out + 8'h01;
      run_reg <= cutoff_in ? run_reg + 8'h01 : 8'h00;
      if (!cutoff_in && cut_d_reg) pulse_len_out <= run_reg;
      if (lowp_cmd_in && !lpc_d_reg) closure_cnt_out <= closure_cnt_out + 8'h01;
      crun_reg <= lowp_cmd_in ? crun_reg + 8'h01 : 8'h00;
      if (!lowp_cmd_in && lpc_d_reg) closure_len_out <= crun_reg;
      if (inhibit_in !== cutoff_in) rf_gap_out <= rf_gap_out + 8'h01;
    end
  end
endmodule

// *** tb/afec_top_tb.sv ***
// Self-checking bench for the antenna fault escalation block
module afec_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PCYC = 20;
  localparam int unsigned LCYC = 5;
  localparam int unsigned FCYC = 8;
  localparam int unsigned SCYC = 10;
  logic                clk_in            = 1'b0;
  logic                rst_b_in          = 1'b1;
  logic                fault_req         = 1'b0;
  logic                man_reset_in      = 1'b0;
  logic                high_power_cmd_in = 1'b0;
  afec_pkg::afec_cfg_t cfg_in            = 4'h0;
  logic                fault_trig_in;
  logic                cutoff_pulse_out;
  logic                rf_drive_inhibit_out;
  logic                low_power_cmd_out;
  logic                tx_low_power_out;
  afec_pkg::afec_ind_t ind_out;
  logic [7:0]          pulse_cnt;
  logic [7:0]          pulse_len;
  logic [7:0]          closure_cnt;
  logic [7:0]          closure_len;
  logic [7:0]          rf_gap;
  logic                p0;
  int                  fails   = 0;
  int                  checked = 0;
  int                  cyc     = 0;

  // Clock and cycle count
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  afec_top #(.PULSE_CYC(PCYC), .LOWP_CYC(LCYC), .FLASH_CYC(FCYC), .SEC_CYC(SCYC)) uut (
    .clk_in              (clk_in),
    .rst_b_in            (rst_b_in),
    .fault_trig_in       (fault_trig_in),
    .man_reset_in        (man_reset_in),
    .high_power_cmd_in   (high_power_cmd_in),
    .cfg_in              (cfg_in),
    .cutoff_pulse_out    (cutoff_pulse_out),
    .rf_drive_inhibit_out(rf_drive_inhibit_out),
    .low_power_cmd_out   (low_power_cmd_out),
    .tx_low_power_out    (tx_low_power_out),
    .ind_out             (ind_out)
  );

  afec_xmtr_model partner (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .fault_req_in   (fault_req),
    .cutoff_in      (cutoff_pulse_out),
    .inhibit_in     (rf_drive_inhibit_out),
    .lowp_cmd_in    (low_power_cmd_out),
    .fault_trig_out (fault_trig_in),
    .pulse_cnt_out  (pulse_cnt),
    .pulse_len_out  (pulse_len),
    .closure_cnt_out(closure_cnt),
    .closure_len_out(closure_len),
    .rf_gap_out     (rf_gap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, reset and stimulus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic do_reset(input afec_pkg::afec_cfg_t c);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    cfg_in   <= c;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
  endtask

  // Fault level held past the pulse so only its edge may count
  task automatic fire();
    fault_req <= 1'b1;
    repeat (30) @(posedge clk_in);
    fault_req <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic press(input bit hp);
    if (hp) high_power_cmd_in <= 1'b1;
    else man_reset_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    high_power_cmd_in <= 1'b0;
    man_reset_in      <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask

  // Fourth pulse placed just inside or just past the selected window
  task automatic win_run(input logic [1:0] sel, input int extra, input logic exp);
    int t0;
    int w;
    case (sel)
      afec_pkg::WSEL_15: w = afec_pkg::WIN_15_S;
      afec_pkg::WSEL_30: w = afec_pkg::WIN_30_S;
      afec_pkg::WSEL_60: w = afec_pkg::WIN_60_S;
      default:           w = afec_pkg::WIN_90_S;
    endcase
    w = w * SCYC;
    do_reset({2'h0, sel});
    t0 = cyc;
    repeat (3) fire();
    while (cyc < t0 + w + extra) @(posedge clk_in);
    fire();
    chk("window_tx_low", {31'h0, tx_low_power_out}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    rst_b_in <= 1'b0;
    do_reset(4'h0);
    chk("reset_out", {rf_drive_inhibit_out, cutoff_pulse_out, low_power_cmd_out}, 32'h0);
    chk("reset_state", {tx_low_power_out, ind_out}, 32'h0);
    fire();
    chk("pulse_count", pulse_cnt, 32'h1);
    chk("pulse_width", pulse_len, PCYC);
    chk("rf_gap", rf_gap, 32'h0);
    chk("trip", ind_out.fault_trip_indicator, 32'h1);
    chk("prot", ind_out.protection_operated_indicator, 32'h1);
    press(1'b0);
    chk("trip_cleared", ind_out.fault_trip_indicator, 32'h0);
    $display("test single_pulse done");

    for (int s = 0; s < 4; s++) begin
      win_run(s[1:0], -15, 1'b1);
      win_run(s[1:0], 15, 1'b0);
    end
    $display("test window done");

    do_reset(4'h8);
    repeat (4) fire();
    chk("disabled_pulses", pulse_cnt, 32'h0);
    chk("disabled_trip", ind_out.fault_trip_indicator, 32'h1);
    cfg_in.op_disable <= 1'b0;
    repeat (3) fire();
    chk("no_count_disabled", tx_low_power_out, 32'h0);
    fire();
    chk("low_power", tx_low_power_out, 32'h1);
    chk("low_ind", ind_out.low_power_indicator, 32'h1);
    chk("closures", closure_cnt, 32'h1);
    chk("closure_len", closure_len, LCYC);
    repeat (4) fire();
    chk("plate_supply_shutdown_latch", ind_out.plate_supply_shutdown_latch, 32'h1);
    chk("rf_gap_all", rf_gap, 32'h0);
    p0 = ind_out.protection_operated_indicator;
    repeat (FCYC) @(posedge clk_in);
    chk("flash", ind_out.protection_operated_indicator, {31'h0, ~p0});
    press(1'b1);
    chk("hp_in_lock", tx_low_power_out, 32'h1);
    press(1'b0);
    chk("lock_cleared", ind_out.plate_supply_shutdown_latch, 32'h0);
    chk("reclose_low", tx_low_power_out, 32'h1);
    press(1'b1);
    chk("high_power", tx_low_power_out, 32'h0);
    $display("test escalation done");

    do_reset(4'h4);
    repeat (4) fire();
    chk("defeat_ind", ind_out.low_power_indicator, 32'h1);
    chk("defeat_full", tx_low_power_out, 32'h0);
    chk("defeat_closure", closure_cnt, 32'h0);
    repeat (4) fire();
    chk("defeat_lock", ind_out.plate_supply_shutdown_latch, 32'h1);
    // Power was full before plate_supply_shutdown_latch, so reclose must pull it low
    press(1'b0);
    chk("defeat_reclose", tx_low_power_out, 32'h1);
    chk("defeat_unlock", ind_out.plate_supply_shutdown_latch, 32'h0);
    $display("test defeat done");
    wrap_up();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    wrap_up();
  end
endmodule
